/* File: src/liu_status_pkg.sv */
// package: register map, field layout and state record for the line status/shape bank
package liu_status_pkg;

  // apb geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CHG_FLAGS = 8'h00; // liu_change_interrupt_flags
  localparam logic [ADDR_W-1:0] OFF_LIVE_STAT = 8'h04; // live condition status
  localparam logic [ADDR_W-1:0] OFF_ATTEN     = 8'h08; // cable_attenuation_readout
  localparam logic [ADDR_W-1:0] OFF_SEG_ONE   = 8'h0c; // pulse_shape_segment_one
  localparam logic [ADDR_W-1:0] OFF_LINE_CTRL = 8'h10; // line configuration
  localparam logic [ADDR_W-1:0] OFF_INT_STAT  = 8'h14; // sticky interrupt status, ro
  localparam logic [ADDR_W-1:0] OFF_INT_CLR   = 8'h18; // interrupt clear, wo, write one
  localparam logic [ADDR_W-1:0] OFF_INT_EN    = 8'h1c; // interrupt enable

  // event / status bit positions (shared by flags, live status and interrupts)
  localparam int EVT_W       = 3;
  localparam int BIT_PATTERN = 0;
  localparam int BIT_LOSS    = 1;
  localparam int BIT_AIS     = 2;
  // only these flags also clear on a write of one
  localparam logic [EVT_W-1:0] WC_MASK = 3'h3;

  // line configuration fields
  localparam int CTL_SINGLE_RAIL = 0;
  localparam int CTL_EXT_LOSS    = 1;
  localparam int CTL_RX_SYNC     = 2;
  localparam int CTL_EQC_LSB     = 3;
  localparam int EQC_W           = 5;
  localparam logic [7:0] LINE_CTRL_RESET = 8'h00;

  // field widths
  localparam int ATTEN_W      = 6;
  localparam int SEG_W        = 7;
  localparam int SEG_SIGN_BIT = 6;
  localparam int LOSS_CNT_W   = 13;

  // loss detection windows in received bits
  localparam int LOSS_WINDOW_EXT_BITS = 4096;
  localparam int LOSS_WINDOW_STD_BITS = 32;

  // default equalizer code that selects arbitrary pulse shape
  localparam logic [EQC_W-1:0] EQC_ARB_CODE = 5'h1f;

  // whole state of the bank
  typedef struct packed {
    logic                    pready;
    logic                    pslverr;
    logic [DATA_W-1:0]       prdata;
    logic [EVT_W-1:0]        chg_flags;
    logic [EVT_W-1:0]        live_prev;
    logic                    loss;
    logic [LOSS_CNT_W-1:0]   zero_run;
    logic [ATTEN_W-1:0]      atten;
    logic [SEG_W-1:0]        seg_one;
    logic [7:0]              line_ctrl;
    logic [EVT_W-1:0]        int_stat;
    logic [EVT_W-1:0]        int_en;
    logic                    irq;
    logic                    arb_mode;
  } state_t;

  localparam state_t STATE_RESET = '{line_ctrl: LINE_CTRL_RESET, default: '0};

endpackage

/* File: src/liu_channel_status_shape_regs.sv */
// line interface status flags, attenuation readout and pulse segment one, apb slave
//
// Overview of operation
// (RULE1) ais change flag sets whenever ais detect state changes; read clears it.
// (RULE2) software uses ais change flag only with framer bypassed.
// (RULE3) rx loss change flag sets on loss change; read or write clears.
// (RULE4) live rx loss condition readable at bit 1 of live status.
// (RULE5) pattern change flag sets on pattern detect change; read or write clears.
// (RULE6) status and change flags work only in single-rail line mode.
// (RULE7) software puts framer into single-rail too when line is single-rail.
// (RULE8) read-only 6-bit attenuation code equals equalizer setting; top bits zero.
// (RULE9) attenuation field bit 5 is msb, bit 0 is lsb.
// (RULE10) extended loss option gives a 4096-bit loss detection window.
// (RULE11) monitor may compare attenuation against threshold within 175 +/-75 cycles.
// (RULE12) software keeps internal loss alarm masked unless extended option used.
// (RULE13) read-write 7-bit pulse segment one; bit 7 reserved.
// (RULE14) segment is sign-magnitude: bit 6 sign, bits 5..0 magnitude.
// (RULE15) software selects arbitrary shape via equalizer control field.
// (RULE16) change in same cycle as clearing read keeps its flag set.
`timescale 1ns/10ps
module liu_channel_status_shape_regs #(
  parameter logic [liu_status_pkg::LOSS_CNT_W-1:0] LOSS_WINDOW_EXT =
    13'(liu_status_pkg::LOSS_WINDOW_EXT_BITS),
  parameter logic [liu_status_pkg::LOSS_CNT_W-1:0] LOSS_WINDOW_STD =
    13'(liu_status_pkg::LOSS_WINDOW_STD_BITS),
  parameter logic [liu_status_pkg::EQC_W-1:0]      EQC_ARB        =
    liu_status_pkg::EQC_ARB_CODE
) (
  // clock and reset
  input  wire logic                                CLOCK_I,
  input  wire logic                                RESETN_I,
  // apb slave
  input  wire logic                                PSEL_I,
  input  wire logic                                PENABLE_I,
  input  wire logic                                PWRITE_I,
  input  wire logic [liu_status_pkg::ADDR_W-1:0]   PADDR_I,
  input  wire logic [liu_status_pkg::DATA_W-1:0]   PWDATA_I,
  output logic      [liu_status_pkg::DATA_W-1:0]   PRDATA_O,
  output logic                                     PREADY_O,
  output logic                                     PSLVERR_O,
  // line conditions
  input  wire logic                                AIS_DETECT_I,
  input  wire logic                                PATTERN_DETECT_I,
  input  wire logic                                RX_BIT_STROBE_I,
  input  wire logic                                RX_BIT_I,
  input  wire logic [liu_status_pkg::ATTEN_W-1:0]  EQ_SETTING_I,
  // transmit pulse shape
  output logic      [liu_status_pkg::SEG_W-1:0]    PULSE_SEGMENT_O,
  output logic                                     SEGMENT_SIGN_O,
  output logic      [liu_status_pkg::SEG_W-2:0]    SEGMENT_MAG_O,
  output logic                                     ARB_MODE_O,
  // alarms
  output logic                                     RX_LOSS_O,
  output logic                                     IRQ_O
);
  import liu_status_pkg::*;

  state_t s_q;
  state_t s_d;

  // decoded bus phases and line conditions, shared by next-state logic and checks
  logic setup;
  logic access;
  logic single_rail;
  logic [EVT_W-1:0] live;
  logic [EVT_W-1:0] change;
  logic [LOSS_CNT_W-1:0] window;

  // bus phases: pready rises in the access phase, so every transfer takes two cycles
  assign setup       = PSEL_I & ~PENABLE_I;
  assign access      = PSEL_I & PENABLE_I & s_q.pready;
  assign single_rail = s_q.line_ctrl[CTL_SINGLE_RAIL];
  // (RULE10) window choice
  assign window      = s_q.line_ctrl[CTL_EXT_LOSS] ? LOSS_WINDOW_EXT : LOSS_WINDOW_STD;

  // live conditions; meaningless outside single-rail so they read as zero there
  always_comb begin
    live = '0;
    // (RULE6) single-rail gating
    if (single_rail) begin
      live[BIT_AIS]     = AIS_DETECT_I;
      live[BIT_LOSS]    = s_q.loss;
      live[BIT_PATTERN] = PATTERN_DETECT_I;
    end
  end

  // (RULE1) change detection per cycle
  assign change = live ^ s_q.live_prev;

  // next state of the whole bank
  always_comb begin
    logic [DATA_W-1:0] rdata;
    logic              unmapped;
    logic              wr;
    logic [EVT_W-1:0]  clr_mask;
    logic [EVT_W-1:0]  int_clr;
    rdata    = '0;
    unmapped = 1'b0;
    wr       = access & PWRITE_I & ~s_q.pslverr;
    clr_mask = '0;
    int_clr  = '0;
    s_d      = s_q;

    // read mux, sampled in the setup cycle and held through the access phase
    if (PADDR_I == OFF_CHG_FLAGS) begin
      rdata[EVT_W-1:0] = s_q.chg_flags;
    end else if (PADDR_I == OFF_LIVE_STAT) begin
      // (RULE4) live loss at bit 1
      rdata[EVT_W-1:0] = live;
    end else if (PADDR_I == OFF_ATTEN) begin
      // (RULE8) upper bits stay zero
      rdata[ATTEN_W-1:0] = s_q.atten;
    end else if (PADDR_I == OFF_SEG_ONE) begin
      rdata[SEG_W-1:0] = s_q.seg_one;
    end else if (PADDR_I == OFF_LINE_CTRL) begin
      rdata[7:0] = s_q.line_ctrl;
    end else if (PADDR_I == OFF_INT_STAT) begin
      rdata[EVT_W-1:0] = s_q.int_stat;
    end else if (PADDR_I == OFF_INT_CLR) begin
      rdata = '0; // write-only
    end else if (PADDR_I == OFF_INT_EN) begin
      rdata[EVT_W-1:0] = s_q.int_en;
    end else begin
      unmapped = 1'b1;
    end

    s_d.pready = setup;
    if (setup) begin
      s_d.prdata  = PWRITE_I ? '0 : rdata;
      s_d.pslverr = unmapped;
    end else if (access) begin
      s_d.prdata  = '0;
      s_d.pslverr = 1'b0;
    end

    // (RULE3) (RULE5) read clears reported bits, write of one clears too
    if (access && !PWRITE_I && PADDR_I == OFF_CHG_FLAGS) begin
      clr_mask = s_q.prdata[EVT_W-1:0];
    end else if (wr && PADDR_I == OFF_CHG_FLAGS) begin
      clr_mask = PWDATA_I[EVT_W-1:0] & WC_MASK;
    end

    // register writes
    if (wr && PADDR_I == OFF_SEG_ONE) begin
      // (RULE13) seven bits kept, reserved bit dropped
      s_d.seg_one = PWDATA_I[SEG_W-1:0];
    end
    if (wr && PADDR_I == OFF_LINE_CTRL) begin
      s_d.line_ctrl = PWDATA_I[7:0];
    end
    if (wr && PADDR_I == OFF_INT_EN) begin
      s_d.int_en = PWDATA_I[EVT_W-1:0];
    end
    if (wr && PADDR_I == OFF_INT_CLR) begin
      int_clr = PWDATA_I[EVT_W-1:0];
    end

    // (RULE16) set wins over clear
    s_d.chg_flags = (s_q.chg_flags & ~clr_mask) | change;
    s_d.int_stat  = (s_q.int_stat & ~int_clr) | change;
    s_d.live_prev = live;

    // (RULE8) attenuation follows the equalizer every cycle
    // (RULE9) msb to msb, no reordering
    s_d.atten = EQ_SETTING_I;

    // (RULE10) loss detector: run of zero bits up to the selected window
    if (RX_BIT_STROBE_I) begin
      if (RX_BIT_I) begin
        s_d.zero_run = '0;
        s_d.loss     = 1'b0;
      end else if (s_q.zero_run < window) begin
        s_d.zero_run = s_q.zero_run + 1'b1;
        s_d.loss     = (s_q.zero_run + 1'b1) >= window;
      end else begin
        s_d.loss = 1'b1;
      end
    end

    // registered from next state so irq tracks status without extra lag
    s_d.irq      = |(s_d.int_stat & s_d.int_en);
    s_d.arb_mode = (s_d.line_ctrl[CTL_EQC_LSB +: EQC_W] == EQC_ARB);
  end

  // single state register, synchronous reset
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      s_q <= STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign PRDATA_O        = s_q.prdata;
  assign PREADY_O        = s_q.pready;
  assign PSLVERR_O       = s_q.pslverr;
  assign PULSE_SEGMENT_O = s_q.seg_one;
  // (RULE14) sign-magnitude split
  assign SEGMENT_SIGN_O  = s_q.seg_one[SEG_SIGN_BIT];
  assign SEGMENT_MAG_O   = s_q.seg_one[SEG_SIGN_BIT-1:0];
  assign ARB_MODE_O      = s_q.arb_mode;
  assign RX_LOSS_O       = s_q.loss;
  assign IRQ_O           = s_q.irq;

  // checks
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESETN_I);

  a_ais_change_sets: assert property ( // RULE1
    change[BIT_AIS] |=> s_q.chg_flags[BIT_AIS])
    else $error("ais change flag not set");

  a_loss_read_clears: assert property ( // RULE3
    access && !PWRITE_I && PADDR_I == OFF_CHG_FLAGS && s_q.prdata[BIT_LOSS]
      && !change[BIT_LOSS] |=> !s_q.chg_flags[BIT_LOSS])
    else $error("loss flag survived read");

  a_live_loss_bit: assert property ( // RULE4
    setup && !PWRITE_I && PADDR_I == OFF_LIVE_STAT && single_rail
      |=> PRDATA_O[BIT_LOSS] == $past(s_q.loss) && PREADY_O)
    else $error("live loss bit wrong");

  a_pattern_write_clr: assert property ( // RULE5
    access && PWRITE_I && !s_q.pslverr && PADDR_I == OFF_CHG_FLAGS
      && PWDATA_I[BIT_PATTERN] && !change[BIT_PATTERN]
      |=> !s_q.chg_flags[BIT_PATTERN])
    else $error("pattern flag survived write");

  a_split_rail_quiet: assert property ( // RULE6
    !single_rail && s_q.live_prev == '0 && s_q.chg_flags == '0
      |=> s_q.chg_flags == '0)
    else $error("flag set outside single rail");

  a_atten_readout: assert property ( // RULE8
    setup && !PWRITE_I && PADDR_I == OFF_ATTEN
      |=> PRDATA_O == {26'h0, $past(s_q.atten)})
    else $error("attenuation readout wrong");

  a_atten_bit_order: assert property ( // RULE9
    1'b1 |=> s_q.atten[5] == $past(EQ_SETTING_I[5]) && s_q.atten[0] == $past(EQ_SETTING_I[0]))
    else $error("attenuation bit order wrong");

  a_ext_window_hit: assert property ( // RULE10
    s_q.line_ctrl[CTL_EXT_LOSS] && RX_BIT_STROBE_I && !RX_BIT_I
      && s_q.zero_run == LOSS_WINDOW_EXT - 13'h1 |=> RX_LOSS_O)
    else $error("extended loss window missed");

  a_segment_write: assert property ( // RULE13
    access && PWRITE_I && !s_q.pslverr && PADDR_I == OFF_SEG_ONE
      |=> PULSE_SEGMENT_O == $past(PWDATA_I[6:0]))
    else $error("segment one not stored");

  a_segment_sign: assert property ( // RULE14
    $changed(PULSE_SEGMENT_O) |-> SEGMENT_SIGN_O == PULSE_SEGMENT_O[6]
      && SEGMENT_MAG_O == PULSE_SEGMENT_O[5:0])
    else $error("sign magnitude split wrong");

  a_set_beats_clear: assert property ( // RULE16
    access && !PWRITE_I && PADDR_I == OFF_CHG_FLAGS && change[BIT_AIS]
      |=> s_q.chg_flags[BIT_AIS])
    else $error("event lost under read clear");

  // read and write-one clears, per flag
  a_ais_read_clears: assert property ( // RULE1
    access && !PWRITE_I && PADDR_I == OFF_CHG_FLAGS && s_q.prdata[BIT_AIS]
      && !change[BIT_AIS] |=> !s_q.chg_flags[BIT_AIS])
    else $error("ais flag survived read");

  // ais flag is read-clear only, so a write of one must leave it alone
  a_ais_write_keeps: assert property ( // RULE1
    access && PWRITE_I && PADDR_I == OFF_CHG_FLAGS && s_q.chg_flags[BIT_AIS]
      |=> s_q.chg_flags[BIT_AIS])
    else $error("ais flag cleared by write");

  a_loss_change_sets: assert property ( // RULE3
    change[BIT_LOSS] |=> s_q.chg_flags[BIT_LOSS])
    else $error("loss change flag not set");

  a_loss_write_clr: assert property ( // RULE3
    access && PWRITE_I && PADDR_I == OFF_CHG_FLAGS && PWDATA_I[BIT_LOSS]
      && !change[BIT_LOSS] |=> !s_q.chg_flags[BIT_LOSS])
    else $error("loss flag survived write");

  a_pattern_change_sets: assert property ( // RULE5
    change[BIT_PATTERN] |=> s_q.chg_flags[BIT_PATTERN])
    else $error("pattern change flag not set");

  a_pattern_read_clr: assert property ( // RULE5
    access && !PWRITE_I && PADDR_I == OFF_CHG_FLAGS && s_q.prdata[BIT_PATTERN]
      && !change[BIT_PATTERN] |=> !s_q.chg_flags[BIT_PATTERN])
    else $error("pattern flag survived read");

  // live status is masked outside single rail
  a_live_rail_gate: assert property ( // RULE6
    !single_rail |-> live == '0)
    else $error("live bits visible outside single rail");

  a_live_split_zero: assert property ( // RULE6
    setup && !PWRITE_I && PADDR_I == OFF_LIVE_STAT && !single_rail |=> PRDATA_O == '0)
    else $error("live status read outside single rail");

  // readout layout of the narrow registers
  a_atten_upper_zero: assert property ( // RULE8
    setup && !PWRITE_I && PADDR_I == OFF_ATTEN |=> PRDATA_O[DATA_W-1:ATTEN_W] == '0)
    else $error("attenuation upper bits not zero");

  a_segment_reserved: assert property ( // RULE13
    setup && !PWRITE_I && PADDR_I == OFF_SEG_ONE
      |=> PRDATA_O[DATA_W-1:SEG_W] == '0 && PRDATA_O[SEG_W-1:0] == $past(s_q.seg_one))
    else $error("segment one readback wrong");

  a_segment_hold: assert property ( // RULE13
    !(access && PWRITE_I && PADDR_I == OFF_SEG_ONE) |=> $stable(PULSE_SEGMENT_O))
    else $error("segment one changed without a write");

  // loss detector windows; the count saturates so a long run cannot wrap
  a_std_window_hit: assert property ( // RULE10
    !s_q.line_ctrl[CTL_EXT_LOSS] && RX_BIT_STROBE_I && !RX_BIT_I
      && s_q.zero_run == LOSS_WINDOW_STD - 13'h1 |=> RX_LOSS_O)
    else $error("standard loss window missed");

  a_loss_early_quiet: assert property ( // RULE10
    !RX_LOSS_O && RX_BIT_STROBE_I && (s_q.zero_run + 13'h1) < window |=> !RX_LOSS_O)
    else $error("loss raised before window");

  a_one_bit_clears: assert property ( // RULE10
    RX_BIT_STROBE_I && RX_BIT_I |=> !RX_LOSS_O && s_q.zero_run == '0)
    else $error("one bit did not clear loss");

  // event and clear in one cycle: the event must win
  a_loss_set_wins: assert property ( // RULE16
    access && !PWRITE_I && PADDR_I == OFF_CHG_FLAGS && change[BIT_LOSS]
      |=> s_q.chg_flags[BIT_LOSS])
    else $error("loss event lost under read clear");

  a_write_set_wins: assert property ( // RULE16
    access && PWRITE_I && PADDR_I == OFF_CHG_FLAGS && |change
      |=> (s_q.chg_flags & $past(change)) == $past(change))
    else $error("event lost under write clear");

  // interrupt status is sticky like the flags
  a_int_stat_sets: assert property ( // RULE16
    |change |=> (s_q.int_stat & $past(change)) == $past(change))
    else $error("interrupt status missed an event");

  // bus timing: one wait-free access phase per transfer
  a_ready_after_setup: assert property (
    setup |=> PREADY_O)
    else $error("ready missing after setup");

  a_ready_one_cycle: assert property (
    PREADY_O |=> !PREADY_O)
    else $error("ready held too long");

  a_unmapped_error: assert property (
    setup && PADDR_I > OFF_INT_EN |=> PSLVERR_O && PRDATA_O == '0)
    else $error("unmapped address not refused");

  c_flag_read: cover property (
    access && !PWRITE_I && PADDR_I == OFF_CHG_FLAGS && s_q.prdata[BIT_AIS]);
  c_loss_raise: cover property (!RX_LOSS_O ##1 RX_LOSS_O);
  c_irq_raise: cover property (!IRQ_O ##1 IRQ_O);
  c_arb_mode: cover property (ARB_MODE_O && PULSE_SEGMENT_O[6]);
  c_set_wins: cover property (
    access && !PWRITE_I && PADDR_I == OFF_CHG_FLAGS && change[BIT_AIS] && s_q.prdata[BIT_AIS]);

endmodule // liu_channel_status_shape_regs

/* File: test/testbench.sv */
// self-checking apb testbench for the line status, attenuation and pulse segment bank
`timescale 1ns/10ps
module testbench;
  import liu_status_pkg::*;

  logic                clock;
  logic                resetn;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [ADDR_W-1:0]   paddr;
  logic [DATA_W-1:0]   pwdata;
  logic [DATA_W-1:0]   prdata;
  logic                pready;
  logic                pslverr;
  logic                ais;
  logic                pat;
  logic                stb;
  logic                rxb;
  logic [ATTEN_W-1:0]  eq;
  logic [SEG_W-1:0]    seg;
  logic                sgn;
  logic [SEG_W-2:0]    mag;
  logic                arb;
  logic                loss;
  logic                irq;
  logic [DATA_W-1:0]   rd;
  logic                er;
  int                  errors;
  int                  total_checks;

  // short loss windows keep the run brief; expectations use these same figures
  liu_channel_status_shape_regs #(
    .LOSS_WINDOW_EXT (13'd16),
    .LOSS_WINDOW_STD (13'd8)
  ) u_liu_channel_status_shape_regs (
    .CLOCK_I (clock), .RESETN_I (resetn), .PSEL_I (psel), .PENABLE_I (penable),
    .PWRITE_I (pwrite), .PADDR_I (paddr), .PWDATA_I (pwdata), .PRDATA_O (prdata),
    .PREADY_O (pready), .PSLVERR_O (pslverr), .AIS_DETECT_I (ais),
    .PATTERN_DETECT_I (pat), .RX_BIT_STROBE_I (stb), .RX_BIT_I (rxb),
    .EQ_SETTING_I (eq), .PULSE_SEGMENT_O (seg), .SEGMENT_SIGN_O (sgn),
    .SEGMENT_MAG_O (mag), .ARB_MODE_O (arb), .RX_LOSS_O (loss), .IRQ_O (irq)
  );

  // free-running 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic test_done;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; tog flips the ais input together with penable so that the
  // change lands on the very edge that performs the read clear
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     input logic tog);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    if (tog) ais <= ~ais;
    // wait for ready; a hang is ended by the watchdog
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 1'b0);
    chk(rd, exp);
  endtask

  // let registered outputs settle before looking at them
  task automatic settle;
    repeat (2) @(posedge clock);
    #1;
  endtask

  task automatic bits(input int n, input logic b);
    repeat (n) begin
      @(posedge clock);
      stb <= 1'b1;
      rxb <= b;
    end
    @(posedge clock);
    stb <= 1'b0;
    settle();
  endtask

  // watchdog: the whole sequence needs well under 2,000 cycles
  initial begin
    #100000;
    errors++;
    test_done();
  end

  initial begin
    {psel, penable, pwrite, ais, pat, stb, rxb} = '0;
    paddr = '0;
    pwdata = '0;
    eq = '0;
    resetn = 1'b0;
    errors = 0;
    total_checks = 0;
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    // reset values, the write-only clear register skipped
    for (int i = 0; i < 8; i++) if (i != 6) rdc(8'(4 * i), 32'h0);
    apb(1'b0, 8'h20, 32'h0, 1'b0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    @(posedge clock); ais <= 1'b1;
    settle();
    @(posedge clock); ais <= 1'b0;
    settle();
    rdc(OFF_CHG_FLAGS, 32'h0);
    wr(OFF_LINE_CTRL, 32'h1);
    // loss interrupt stays masked while the extended option is off
    wr(OFF_INT_EN, 32'h5);
    @(posedge clock); ais <= 1'b1;
    settle();
    chk({31'h0, irq}, 32'h1);
    rdc(OFF_LIVE_STAT, 32'h4);
    rdc(OFF_CHG_FLAGS, 32'h4);
    rdc(OFF_CHG_FLAGS, 32'h0);
    rdc(OFF_INT_STAT, 32'h4);
    wr(OFF_INT_CLR, 32'h4);
    settle();
    chk({31'h0, irq}, 32'h0);
    @(posedge clock); ais <= 1'b0;
    settle();
    wr(OFF_CHG_FLAGS, 32'h7);
    rdc(OFF_CHG_FLAGS, 32'h4);
    // pattern change, write and read clear
    @(posedge clock); pat <= 1'b1;
    settle();
    wr(OFF_CHG_FLAGS, 32'h1);
    rdc(OFF_CHG_FLAGS, 32'h0);
    @(posedge clock); pat <= 1'b0;
    settle();
    rdc(OFF_CHG_FLAGS, 32'h1);
    rdc(OFF_CHG_FLAGS, 32'h0);
    // change on the clearing read edge survives
    @(posedge clock); ais <= ~ais;
    settle();
    apb(1'b0, OFF_CHG_FLAGS, 32'h0, 1'b1);
    chk(rd, 32'h4);
    rdc(OFF_CHG_FLAGS, 32'h4);
    rdc(OFF_CHG_FLAGS, 32'h0);
    // loss over the standard window of 8
    bits(7, 1'b0);
    chk({31'h0, loss}, 32'h0);
    bits(1, 1'b0);
    chk({31'h0, loss}, 32'h1);
    rdc(OFF_LIVE_STAT, 32'h2);
    rdc(OFF_CHG_FLAGS, 32'h2);
    bits(1, 1'b1);
    chk({31'h0, loss}, 32'h0);
    wr(OFF_CHG_FLAGS, 32'h2);
    rdc(OFF_CHG_FLAGS, 32'h0);
    wr(OFF_LINE_CTRL, 32'h7);
    bits(8, 1'b0);
    chk({31'h0, loss}, 32'h0);
    bits(8, 1'b0);
    chk({31'h0, loss}, 32'h1);
    bits(1, 1'b1);
    // attenuation code, writes ignored
    // codes that are not bit palindromes, so a reversed field would show
    @(posedge clock); eq <= 6'h23;
    settle();
    wr(OFF_ATTEN, 32'hff);
    rdc(OFF_ATTEN, 32'h23);
    chk({31'h0, rd[5:0] >= 6'h0c}, 32'h1);
    @(posedge clock); eq <= 6'h1c;
    settle();
    rdc(OFF_ATTEN, 32'h1c);
    chk({31'h0, rd[5:0] >= 6'h0c}, 32'h1);
    wr(OFF_SEG_ONE, 32'hffffffff);
    rdc(OFF_SEG_ONE, 32'h7f);
    wr(OFF_SEG_ONE, 32'h45);
    settle();
    chk({25'h0, seg}, 32'h45);
    chk({31'h0, sgn}, 32'h1);
    chk({26'h0, mag}, 32'h05);
    wr(OFF_SEG_ONE, 32'h3a);
    settle();
    chk({25'h0, sgn, mag}, 32'h3a);
    // arbitrary shape selected by the equalizer field
    wr(OFF_LINE_CTRL, 32'hf9);
    settle();
    chk({31'h0, arb}, 32'h1);
    wr(OFF_LINE_CTRL, 32'h01);
    settle();
    chk({31'h0, arb}, 32'h0);
    // interrupt masked, then unmasked and cleared
    wr(OFF_INT_CLR, 32'h7);
    wr(OFF_INT_EN, 32'h0);
    @(posedge clock); ais <= ~ais;
    settle();
    chk({31'h0, irq}, 32'h0);
    rdc(OFF_INT_STAT, 32'h4);
    wr(OFF_INT_EN, 32'h4);
    settle();
    chk({31'h0, irq}, 32'h1);
    wr(OFF_INT_CLR, 32'h4);
    settle();
    chk({31'h0, irq}, 32'h0);
    test_done();
  end
endmodule // testbench
